// file: rtl/secure_link_table_update.sv
// Purpose: Secure link table upkeep from host commands and radio resync
// Assumes: rx/tel/tx streams are clk_sys logic, no synchronisers needed
// Notes:   Table of four entries plus one broadcast set
// Function
// - Unknown sender teach-in telegram dropped, table kept
// - Known sender, right key, same format and info byte: overwrite rolling code
// - Report successful resync to host
// - Accept and apply add-entry command 0x38
// - Add-entry may load receive-side parameters too
// - Direction byte picks remote or local part
// - Direction 0 remote default, 1 local, rest unused; command without direction byte not applied
// - Local with own or zero ID: broadcast
// - Local with other ID: addressed destination
// - Packet framing, lengths and field offsets fixed
// - Short rolling code ignores unused upper bytes
// - Teach-in info byte stored with entry
// - Event code 0x05, type 0x0A plus ID
// - Wrong key telegram ignored, reported 0x02
`timescale 1ns/1ps
`default_nettype none
module secure_link_table_update
  import slt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  input  wire logic        tel_valid,
  input  wire tel_s        tel,
  output logic             tel_ready,
  input  wire logic        teach_mode_active,
  input  wire logic [31:0] own_radio_id,
  output logic             cmd_applied
);
  state_s            s;
  state_s            n;
  logic [16:0]       body_total;
  logic              cmd_ok;
  logic [7:0]        cmd_dir;
  logic              dir_ok;
  logic [31:0]       cmd_id;
  logic [127:0]      cmd_key;
  logic [31:0]       cmd_rlc;
  logic [7:0]        cmd_slf;
  logic [7:0]        cmd_tii;
  logic              cmd_hit;
  logic [IDX_W-1:0]  cmd_idx;
  logic              free_ok;
  logic [IDX_W-1:0]  free_idx;
  logic [IDX_W-1:0]  slot;
  logic              dcrc_good;
  logic              host_apply;
  logic              bcast_id;
  logic              tel_take;
  logic              tel_hit;
  logic [IDX_W-1:0]  tel_idx;
  logic              key_ok;
  logic              aux_ok;
  logic [31:0]       resync_rlc;

  function automatic logic [IDX_W:0] find_id(input entry_s [TABLE_DEPTH-1:0] t,
                                             input logic [31:0] id);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
      if (t[i].used && t[i].id == id) begin
        r = {1'b1, i[IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] evt_byte(input logic [3:0]  idx,
                                          input logic [7:0]  crc,
                                          input logic [7:0]  typ,
                                          input logic [31:0] id);
    logic [7:0] b;
    case (idx)
      4'h1:    b = EVT_LEN[15:8];
      4'h2:    b = EVT_LEN[7:0];
      4'h3:    b = EVT_OPT_LEN;
      4'h4:    b = PTYPE_EVENT;
      4'h5:    b = crc;
      4'h6:    b = EVT_CODE;
      4'h7:    b = typ;
      4'h8:    b = id[31:24];
      4'h9:    b = id[23:16];
      4'ha:    b = id[15:8];
      4'hb:    b = id[7:0];
      4'hc:    b = crc;
      default: b = SYNC_BYTE;
    endcase
    return b;
  endfunction

  always_comb begin
    body_total = {1'b0, s.len} + {9'h000, s.opt};
    cmd_ok     = (s.ptype == PTYPE_CMD) && (s.len == ADD_LEN) &&
                 (s.opt >= ADD_OPT_LEN) && (s.body[0] == CMD_ADD);
    cmd_slf    = s.body[PKT_SLF-DATA_START];
    cmd_tii    = s.body[PKT_TII-DATA_START];
    cmd_id     = '0;
    cmd_rlc    = '0;
    cmd_key    = '0;
    for (int i = 0; i < 4; i++) begin
      cmd_id[31-8*i -: 8]  = s.body[PKT_ID-DATA_START+i];
      cmd_rlc[31-8*i -: 8] = s.body[PKT_RLC-DATA_START+i];
    end
    for (int i = 0; i < 16; i++) begin
      cmd_key[127-8*i -: 8] = s.body[PKT_KEY-DATA_START+i];
    end
    cmd_dir = (s.opt != 8'h00) ? s.body[PKT_DIR-DATA_START] : DIR_REMOTE;
    dir_ok  = (cmd_dir == DIR_REMOTE) || (cmd_dir == DIR_LOCAL);
    {cmd_hit, cmd_idx} = find_id(s.links, cmd_id);
    free_ok  = 1'b0;
    free_idx = '0;
    for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
      if (!s.links[i].used) begin
        free_ok  = 1'b1;
        free_idx = i[IDX_W-1:0];
      end
    end
    slot       = cmd_hit ? cmd_idx : free_idx;
    dcrc_good  = rx_valid && (s.rx == RX_DCRC) && (rx_data == s.crc);
    host_apply = dcrc_good && cmd_ok && dir_ok;
    bcast_id   = (cmd_id == own_radio_id) || (cmd_id == 32'h00000000);
    {tel_hit, tel_idx} = find_id(s.links, tel.id);
    tel_take   = tel_valid && s.tel_ready && !teach_mode_active;
    key_ok     = tel.key == s.links[tel_idx].rkey;
    aux_ok     = (tel.security_level_format == s.links[tel_idx].rslf) &&
                 (tel.teach_in_info == s.links[tel_idx].rtii);
    resync_rlc = rlc_mask(s.links[tel_idx].rslf, tel.rolling_code_counter);
  end

  always_comb begin
    n = s;
    n.cmd_applied = 1'b0;
    if (rx_valid) begin
      case (s.rx)
        RX_SYNC: begin
          if (rx_data == SYNC_BYTE) begin
            n.rx  = RX_HDR;
            n.cnt = '0;
            n.crc = CRC_INIT;
          end
        end
        RX_HDR: begin
          n.crc = crc8_step(s.crc, rx_data);
          n.cnt = s.cnt + 17'h00001;
          case (s.cnt[1:0])
            2'h0:    n.len[15:8] = rx_data;
            2'h1:    n.len[7:0]  = rx_data;
            2'h2:    n.opt       = rx_data;
            default: n.ptype     = rx_data;
          endcase
          if (s.cnt[1:0] == 2'h3) begin
            n.rx = RX_HCRC;
          end
        end
        RX_HCRC: begin
          n.crc = CRC_INIT;
          n.cnt = '0;
          if (rx_data != s.crc) begin
            n.rx = RX_SYNC;
          end else if (body_total == 17'h00000) begin
            n.rx = RX_DCRC;
          end else begin
            n.rx = RX_BODY;
          end
        end
        RX_BODY: begin
          n.crc = crc8_step(s.crc, rx_data);
          n.cnt = s.cnt + 17'h00001;
          if (s.cnt < 17'(BUF_BYTES)) begin
            n.body[s.cnt[4:0]] = rx_data;
          end
          if (n.cnt == body_total) begin
            n.rx = RX_DCRC;
          end
        end
        default: n.rx = RX_SYNC;
      endcase
    end
    if (host_apply) begin
      if (cmd_dir == DIR_LOCAL && bcast_id) begin
        n.cmd_applied = 1'b1;
        n.bc.set = 1'b1;
        n.bc.key = cmd_key;
        n.bc.rolling_code_counter = rlc_mask(cmd_slf, cmd_rlc);
        n.bc.security_level_format = cmd_slf;
        n.bc.teach_in_info = cmd_tii;
      end else if (cmd_hit || free_ok) begin
        n.cmd_applied = 1'b1;
        n.links[slot].used = 1'b1;
        n.links[slot].id   = cmd_id;
        if (cmd_dir == DIR_REMOTE) begin
          n.links[slot].rkey = cmd_key;
          n.links[slot].rrlc = rlc_mask(cmd_slf, cmd_rlc);
          n.links[slot].rslf = cmd_slf;
          n.links[slot].rtii = cmd_tii;
        end else begin
          n.links[slot].lkey = cmd_key;
          n.links[slot].lrlc = rlc_mask(cmd_slf, cmd_rlc);
          n.links[slot].lslf = cmd_slf;
          n.links[slot].ltii = cmd_tii;
        end
      end
    end
    if (s.tx_valid && tx_ready) begin
      if (s.tx_idx == EVT_LAST) begin
        n.tx_valid = 1'b0;
      end else begin
        n.tx_idx = s.tx_idx + 4'h1;
        if (s.tx_idx == 4'h0 || s.tx_idx == EVT_HCRC_IDX) begin
          n.tx_crc = CRC_INIT;
        end else begin
          n.tx_crc = crc8_step(s.tx_crc, s.tx_data);
        end
        n.tx_data = evt_byte(n.tx_idx, n.tx_crc, s.evt_type, s.evt_id);
      end
    end
    if (tel_take && tel_hit) begin
      if (!key_ok) begin
        n.evt_type = EVT_WRONG_KEY;
        n.evt_id   = tel.id;
        n.tx_valid = 1'b1;
        n.tx_data  = SYNC_BYTE;
        n.tx_idx   = 4'h0;
        n.tx_crc   = CRC_INIT;
      end else if (aux_ok) begin
        n.links[tel_idx].rrlc = resync_rlc;
        n.evt_type = EVT_RESYNC;
        n.evt_id   = tel.id;
        n.tx_valid = 1'b1;
        n.tx_data  = SYNC_BYTE;
        n.tx_idx   = 4'h0;
        n.tx_crc   = CRC_INIT;
      end
    end
    n.tel_ready = !n.tx_valid;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tx_valid    = s.tx_valid;
  assign tx_data     = s.tx_data;
  assign tel_ready   = s.tel_ready;
  assign cmd_applied = s.cmd_applied;

  AST_UNKNOWN_DROP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (tel_take && !tel_hit && !host_apply) |=>
      !s.tx_valid && $stable(s.links))
    else $error("Unknown sender changed state");

  AST_RESYNC_RLC: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (tel_take && tel_hit && key_ok && aux_ok) |=>
      s.links[$past(tel_idx)].rrlc == $past(resync_rlc))
    else $error("Rolling code not resynchronised");

  AST_RESYNC_EVT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (tel_take && tel_hit && key_ok && aux_ok) |=>
      s.tx_valid && s.evt_type == EVT_RESYNC && s.tx_data == SYNC_BYTE)
    else $error("Resync event not started");

  AST_WRONG_KEY: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (tel_take && tel_hit && !key_ok && !host_apply) |=>
      s.evt_type == EVT_WRONG_KEY && $stable(s.links))
    else $error("Wrong key not reported or table changed");

  AST_EVT_CODE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s.tx_valid && s.tx_idx == 4'h6) |-> s.tx_data == EVT_CODE)
    else $error("Event code byte wrong");

  AST_BAD_CRC: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rx_valid && s.rx == RX_DCRC && rx_data != s.crc && !tel_take) |=>
      !s.cmd_applied && $stable(s.links) && $stable(s.bc))
    else $error("Bad check byte packet applied");

  AST_DIR_UNUSED: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (dcrc_good && cmd_ok && !dir_ok) |=> !s.cmd_applied && $stable(s.bc))
    else $error("Unused direction applied");

  AST_BCAST: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (host_apply && cmd_dir == DIR_LOCAL && bcast_id) |=>
      s.bc.set && s.bc.key == $past(cmd_key) && s.cmd_applied)
    else $error("Broadcast parameters not stored");
endmodule
`default_nettype wire

// file: rtl/slt_pkg.sv
// Purpose: Shared constants and types for the secure link table updater
// Assumes: Host bytes and radio telegrams come from logic on clk_sys
// Notes:   Big-endian multi-byte fields in packets
package slt_pkg;
  localparam int TABLE_DEPTH = 4;
  localparam int IDX_W       = 2;
  localparam int BUF_BYTES   = 32;
  localparam int DATA_START  = 6;
  localparam int PKT_SLF     = 7;
  localparam int PKT_ID      = 8;
  localparam int PKT_KEY     = 12;
  localparam int PKT_RLC     = 28;
  localparam int PKT_TII     = 32;
  localparam int PKT_DIR     = 33;
  localparam logic [7:0]  SYNC_BYTE     = 8'h55;
  localparam logic [7:0]  PTYPE_CMD     = 8'h05;
  localparam logic [7:0]  PTYPE_EVENT   = 8'h04;
  localparam logic [7:0]  CMD_ADD       = 8'h38;
  localparam logic [15:0] ADD_LEN       = 16'h001b;
  localparam logic [7:0]  ADD_OPT_LEN   = 8'h01;
  localparam logic [7:0]  DIR_REMOTE    = 8'h00;
  localparam logic [7:0]  DIR_LOCAL     = 8'h01;
  localparam logic [7:0]  EVT_CODE      = 8'h05;
  localparam logic [7:0]  EVT_RESYNC    = 8'h0a;
  localparam logic [7:0]  EVT_WRONG_KEY = 8'h02;
  localparam logic [15:0] EVT_LEN       = 16'h0006;
  localparam logic [7:0]  EVT_OPT_LEN   = 8'h00;
  localparam logic [3:0]  EVT_HCRC_IDX  = 4'h5;
  localparam logic [3:0]  EVT_LAST      = 4'hc;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'h00;
  localparam int          SLF_RLC_LSB   = 6;
  localparam logic [1:0]  SLF_RLC16     = 2'h1;
  localparam logic [1:0]  SLF_RLC24     = 2'h2;

  typedef enum logic [2:0] {
    RX_SYNC = 3'b000,
    RX_HDR  = 3'b001,
    RX_HCRC = 3'b010,
    RX_BODY = 3'b011,
    RX_DCRC = 3'b100
  } rx_e;

  typedef struct packed {
    logic [31:0]  id;
    logic [127:0] key;
    logic [31:0]  rolling_code_counter;
    logic [7:0]   security_level_format;
    logic [7:0]   teach_in_info;
  } tel_s;

  typedef struct packed {
    logic         used;
    logic [31:0]  id;
    logic [127:0] rkey;
    logic [31:0]  rrlc;
    logic [7:0]   rslf;
    logic [7:0]   rtii;
    logic [127:0] lkey;
    logic [31:0]  lrlc;
    logic [7:0]   lslf;
    logic [7:0]   ltii;
  } entry_s;

  typedef struct packed {
    logic         set;
    logic [127:0] key;
    logic [31:0]  rolling_code_counter;
    logic [7:0]   security_level_format;
    logic [7:0]   teach_in_info;
  } bcast_s;

  typedef struct packed {
    rx_e                               rx;
    logic [16:0]                       cnt;
    logic [15:0]                       len;
    logic [7:0]                        opt;
    logic [7:0]                        ptype;
    logic [7:0]                        crc;
    logic [BUF_BYTES-1:0][7:0]         body;
    entry_s [TABLE_DEPTH-1:0]          links;
    bcast_s                            bc;
    logic                              tx_valid;
    logic [7:0]                        tx_data;
    logic [3:0]                        tx_idx;
    logic [7:0]                        tx_crc;
    logic [7:0]                        evt_type;
    logic [31:0]                       evt_id;
    logic                              tel_ready;
    logic                              cmd_applied;
  } state_s;

  function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] rlc_mask(input logic [7:0]  security_level_format,
                                           input logic [31:0] rolling_code_counter);
    logic [31:0] m;
    m = rolling_code_counter;
    if (security_level_format[SLF_RLC_LSB+:2] == SLF_RLC16) begin
      m = {16'h0000, rolling_code_counter[15:0]};
    end else if (security_level_format[SLF_RLC_LSB+:2] == SLF_RLC24) begin
      m = {8'h00, rolling_code_counter[23:0]};
    end
    return m;
  endfunction
endpackage

// file: verif/host_model.sv
// Purpose: Host controller stand-in on the serial packet link
// Assumes: Bytes driven at the falling edge of clk_sys
// Notes:   Optional stalls on the event stream; event bytes collected
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic       slow;
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
    slow     = 1'b0;
  end

  task automatic send(input logic [279:0] pk);
    for (int i = 0; i < 35; i++) begin
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_data  = pk[279-8*i -: 8];
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  always @(negedge clk_sys) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  always @(posedge clk_sys) begin
    if (rst_n && tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the secure link table updater
// Assumes: Inputs change at the falling edge of clk_sys
// Notes:   Table contents read through the state register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module testbench;
  import slt_pkg::*;
  logic        clk_sys, rst_n, rx_valid, tx_valid, tx_ready;
  logic        tel_valid, tel_ready, teach_mode_active, cmd_applied;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] own_radio_id;
  tel_s        tel;
  int          bad_count, checks, pulses;
  localparam logic [127:0] K1 = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] K2 = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
  localparam logic [31:0]  ID1 = 32'h01020304;
  localparam logic [31:0]  ID2 = 32'h0badf00d;

  secure_link_table_update dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tel_valid(tel_valid), .tel(tel),
    .tel_ready(tel_ready), .teach_mode_active(teach_mode_active),
    .own_radio_id(own_radio_id), .cmd_applied(cmd_applied));

  host_model host_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    if (cmd_applied === 1'b1) pulses++;
  end

  function automatic logic [7:0] crc(input logic [223:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n * 8; i++) begin
      c = (c[7] ^ v[223-i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Add-entry packet; bad 1 spoils header check, 2 the data check
  task automatic add(input logic [31:0] id, input logic [127:0] key,
                     input logic [31:0] rolling_code_counter, input logic [7:0] security_level_format,
                     input logic [7:0] teach_in_info, input logic [7:0] dir,
                     input int bad, input int npulse);
    logic [223:0] body;
    logic [7:0]   hc, dc;
    int           p0;
    body = {8'h38, security_level_format, id, key, rolling_code_counter, teach_in_info, dir};
    hc = crc({32'h001b0105, 192'h0}, 4) ^ ((bad == 1) ? 8'h01 : 8'h00);
    dc = crc(body, 28) ^ ((bad == 2) ? 8'h80 : 8'h00);
    p0 = pulses;
    host_u.send({8'h55, 32'h001b0105, hc, body, dc});
    repeat (4) @(negedge clk_sys);
    `CHK("applied pulses", npulse, pulses - p0)
    `CHK("applied idle", 1'b0, cmd_applied)
  endtask

  task automatic send_tel(input logic [31:0] id, input logic [127:0] key,
                          input logic [31:0] rolling_code_counter, input logic [7:0] security_level_format,
                          input logic [7:0] teach_in_info);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (tel_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk_sys);
    end
    tel_valid = 1'b1;
    tel = {id, key, rolling_code_counter, security_level_format, teach_in_info};
    @(negedge clk_sys);
    tel_valid = 1'b0;
    tel = ~tel;
  endtask

  task automatic expect_evt(input logic [7:0] typ, input logic [31:0] id);
    logic [103:0] ex;
    int           n;
    n = 0;
    while (host_u.got.size() < 13 && n < 200) begin
      n++;
      @(negedge clk_sys);
    end
    ex = {8'h55, 32'h00060004, crc({32'h00060004, 192'h0}, 4),
          8'h05, typ, id, crc({8'h05, typ, id, 176'h0}, 6)};
    `CHK("event size", 13, host_u.got.size())
    for (int i = 0; i < 13 && i < host_u.got.size(); i++) begin
      `CHK("event byte", ex[103-8*i -: 8], host_u.got[i])
    end
    host_u.got.delete();
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    tel_valid = 1'b0;
    tel = '0;
    teach_mode_active = 1'b0;
    own_radio_id = 32'h0a0b0c0d;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    add(ID1, K1, 32'hdeadbeef, 8'h40, 8'h11, 8'h00, 0, 1);
    `CHK("r key", K1, dut_u.s.links[0].rkey)
    `CHK("r rlc", 32'h0000beef, dut_u.s.links[0].rrlc)
    `CHK("r tii", 8'h11, dut_u.s.links[0].rtii)
    add(ID1, K2, 32'h89abcdef, 8'h80, 8'h22, 8'h01, 0, 1);
    `CHK("l key", K2, dut_u.s.links[0].lkey)
    `CHK("l rlc", 32'h00abcdef, dut_u.s.links[0].lrlc)
    `CHK("l tii", 8'h22, dut_u.s.links[0].ltii)
    `CHK("r key kept", K1, dut_u.s.links[0].rkey)
    add(32'h0, K2, 32'h1, 8'h00, 8'h33, 8'h01, 0, 1);
    `CHK("bc key", K2, dut_u.s.bc.key)
    add(32'h0a0b0c0d, K1, 32'h2, 8'h00, 8'h44, 8'h01, 0, 1);
    `CHK("bc own", K1, dut_u.s.bc.key)
    add(ID2, K1, 32'h3, 8'h00, 8'h00, 8'h02, 0, 0);
    add(ID2, K1, 32'h3, 8'h00, 8'h00, 8'hff, 0, 0);
    add(ID2, K2, 32'h3, 8'h00, 8'h00, 8'h00, 1, 0);
    add(ID2, K1, 32'h3, 8'h00, 8'h00, 8'h00, 2, 0);
    `CHK("slot free", 1'b0, dut_u.s.links[1].used)
    send_tel(ID2, K1, 32'h5, 8'h40, 8'h11);
    repeat (40) @(negedge clk_sys);
    `CHK("unknown quiet", 0, host_u.got.size())
    teach_mode_active = 1'b1;
    send_tel(ID1, K1, 32'h12345678, 8'h40, 8'h11);
    repeat (40) @(negedge clk_sys);
    teach_mode_active = 1'b0;
    `CHK("teach quiet", 0, host_u.got.size())
    `CHK("teach rlc kept", 32'h0000beef, dut_u.s.links[0].rrlc)
    host_u.slow = 1'b1;
    send_tel(ID1, K1, 32'h12345678, 8'h40, 8'h11);
    `CHK("busy ready", 1'b0, tel_ready)
    expect_evt(8'h0a, ID1);
    `CHK("ready back", 1'b1, tel_ready)
    `CHK("frame end", 1'b0, tx_valid)
    `CHK("resync rlc", 32'h00005678, dut_u.s.links[0].rrlc)
    send_tel(ID1, K2, 32'h00000099, 8'h40, 8'h11);
    expect_evt(8'h02, ID1);
    `CHK("rlc kept", 32'h00005678, dut_u.s.links[0].rrlc)
    send_tel(ID1, K1, 32'h00000077, 8'h80, 8'h11);
    repeat (40) @(negedge clk_sys);
    `CHK("format quiet", 0, host_u.got.size())
    `CHK("format rlc kept", 32'h00005678, dut_u.s.links[0].rrlc)
    print_verdict();
  end
endmodule
`default_nettype wire
